//--- src/wdt_top.sv
/*
 watchdog timer unit: 15-bit down-counter behind a 16/128 prescaler, refresh,
 start, source protection and underflow action, registers over axi4-lite.
 assumes stop_mode and wait_mode come from logic on ref_clk; the low-speed
 oscillator clock and the option byte are pins and are synchronised here.
*/
`timescale 1ns/100ps
// How it works
// - counter is 15 bits and steps down by one per prescaled tick, or per low-speed edge when protected
// - unprotected counts on the cpu clock, protected on the low-speed oscillator
// - counter reloads on reset, underflow, and a 00h then FFh refresh
// - auto-start bit 1: counter and prescaler wait for a start register write
// - auto-start bit 0: counting begins by itself once reset ends
// - unprotected: stop and wait modes freeze the count, resuming from it
// - unprotected with action bit 0: underflow raises an interrupt request
// - action bit 1: underflow issues a watchdog reset, not an interrupt
// - unprotected timeout is prescaler ratio times 32768 cpu clocks
// - prescaler divides by 16 or 128 chosen by one control bit
// - protected: counting goes on through wait mode once started
// - enabling protection loads 0FFFh, forces oscillator on, selects reset
// - software cannot change the auto-start option bit
module wdt_top
    import wdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WDT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [WDT_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [WDT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [WDT_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_speed_osc_clk,
    input wire logic [WDT_OPT_W-1:0] option_byte,
    input wire logic stop_mode,
    input wire logic wait_mode,
    output logic wdt_irq,
    output logic wdt_reset_req,
    output logic low_speed_osc_force_on
);
    wdt_reg_if rif ();

    logic [WDT_OPT_W:0] pins_sync;
    logic ls_level, ls_prev, next_ls_prev, ls_tick;
    logic [1:0] settle, next_settle;
    logic done, next_done;
    logic [WDT_OPT_W-1:0] opt, next_opt;
    logic [WDT_CNT_W-1:0] cnt, next_cnt;
    logic [WDT_PRE_W-1:0] pre, next_pre;
    logic psel, next_psel;
    logic action, next_action;
    logic prot, next_prot, prot_d, next_prot_d, prot_rise;
    logic armed, next_armed;
    logic started, next_started;
    logic next_irq, next_reset_req;
    logic running, frozen, pre_tick, tick, refresh, underflow;

    function automatic logic wr_to(input logic [WDT_ADDR_W-1:0] a);
        return rif.wr_stb && (rif.wr_addr == a) && rif.wr_strb[0];
    endfunction

    wdt_sync2 #(.W(WDT_OPT_W + 1)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({low_speed_osc_clk, option_byte}),
        .q(pins_sync)
    );

    wdt_axil_slave u_bus (
        .ref_clk(ref_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rif(rif.bus)
    );

    assign ls_level = pins_sync[WDT_OPT_W];
    assign ls_tick = ls_level && !ls_prev;
    assign prot_rise = prot && !prot_d;
    // auto-start bit 1 waits for a start write
    assign running = done && (!opt[WDT_AUTO_BIT] || started);
    // stop and wait freeze only while unprotected
    assign frozen = !prot && (stop_mode || wait_mode);
    // ratio 16 or 128 from the select bit
    assign pre_tick = (pre >= (psel ? WDT_PRE_LIM_128 : WDT_PRE_LIM_16));
    // cpu clock through prescaler, or raw low-speed edges when protected
    assign tick = running && !frozen && (prot ? ls_tick : pre_tick);
    // refresh needs an armed 00h first
    assign refresh = rif.wr_stb && rif.wr_strb[0] && (rif.wr_addr == WDT_ADDR_REFRESH)
        && armed && (rif.wr_data[7:0] == WDT_REFRESH_SECOND);
    assign underflow = tick && (cnt == WDT_CNT_ZERO) && !refresh && !prot_rise;

    // register read mux and decode
    always_comb
    begin
        rif.rd_data = '0;
        rif.rd_hit = 1'b1;
        unique case (rif.rd_addr)
            WDT_ADDR_CTRL: rif.rd_data[WDT_PSEL_BIT] = psel;
            WDT_ADDR_REFRESH: rif.rd_data = '0;
            WDT_ADDR_START: rif.rd_data = '0;
            WDT_ADDR_PROTECT: rif.rd_data[WDT_PROT_BIT] = prot;
            WDT_ADDR_PMODE: rif.rd_data[WDT_ACTION_BIT] = action;
            WDT_ADDR_STATUS: rif.rd_data[WDT_RUN_BIT:0] = {running, cnt};
            WDT_ADDR_OPT: rif.rd_data[WDT_OPT_W-1:0] = opt;
            default: rif.rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (rif.wr_addr)
            WDT_ADDR_CTRL, WDT_ADDR_REFRESH, WDT_ADDR_START, WDT_ADDR_PROTECT,
            WDT_ADDR_PMODE, WDT_ADDR_STATUS, WDT_ADDR_OPT: rif.wr_hit = 1'b1;
            default: rif.wr_hit = 1'b0;
        endcase
    end

    // next state of the timer
    always_comb
    begin
        next_ls_prev = ls_level;
        next_settle = settle;
        next_done = done;
        next_opt = opt;
        next_cnt = cnt;
        next_pre = pre;
        next_psel = psel;
        next_action = action;
        next_prot = prot;
        next_prot_d = prot;
        next_armed = armed;
        next_started = started;
        next_irq = 1'b0;
        next_reset_req = 1'b0;
        // option byte caught once after reset, never written by software
        if (!done)
        begin
            if (settle == WDT_SETTLE)
            begin
                next_done = 1'b1;
                next_opt = pins_sync[WDT_OPT_W-1:0];
                next_prot = !pins_sync[WDT_PROT_INIT_BIT];
            end
            else
            begin
                next_settle = settle + 2'h1;
            end
        end
        if (wr_to(WDT_ADDR_CTRL))
        begin
            next_psel = rif.wr_data[WDT_PSEL_BIT];
        end
        if (wr_to(WDT_ADDR_PMODE) && !prot)
        begin
            next_action = rif.wr_data[WDT_ACTION_BIT];
        end
        if (wr_to(WDT_ADDR_PROTECT) && rif.wr_data[WDT_PROT_BIT])
        begin
            next_prot = 1'b1;
        end
        if (wr_to(WDT_ADDR_START) && done)
        begin
            next_started = 1'b1;
        end
        if (wr_to(WDT_ADDR_REFRESH))
        begin
            next_armed = (rif.wr_data[7:0] == WDT_REFRESH_FIRST);
        end
        // prescaler runs only while the counter does
        if (running && !frozen && !prot)
        begin
            next_pre = pre_tick ? WDT_PRE_ZERO : pre + WDT_PRE_ONE;
        end
        if (prot_rise)
        begin
            next_cnt = WDT_PROT_LOAD;
            next_action = 1'b1;
        end
        else if (refresh)
        begin
            next_cnt = WDT_RELOAD;
        end
        else if (underflow)
        begin
            next_cnt = WDT_RELOAD;
            next_irq = !action;
            next_reset_req = action;
        end
        else if (tick)
        begin
            next_cnt = cnt - WDT_CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ls_prev <= 1'b0;
            settle <= 2'h0;
            done <= 1'b0;
            opt <= '0;
            cnt <= WDT_RELOAD;
            pre <= WDT_PRE_ZERO;
            psel <= 1'b0;
            action <= 1'b0;
            prot <= 1'b0;
            prot_d <= 1'b0;
            armed <= 1'b0;
            started <= 1'b0;
            wdt_irq <= 1'b0;
            wdt_reset_req <= 1'b0;
        end
        else
        begin
            ls_prev <= next_ls_prev;
            settle <= next_settle;
            done <= next_done;
            opt <= next_opt;
            cnt <= next_cnt;
            pre <= next_pre;
            psel <= next_psel;
            action <= next_action;
            prot <= next_prot;
            prot_d <= next_prot_d;
            armed <= next_armed;
            started <= next_started;
            wdt_irq <= next_irq;
            wdt_reset_req <= next_reset_req;
        end
    end

    assign low_speed_osc_force_on = prot_d;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_count_steps: assert property (
        tick && !refresh && !prot_rise && cnt != WDT_CNT_ZERO
        |=> cnt == $past(cnt) - WDT_CNT_ONE)
        else $error("counter did not step down by one");
    a_source_select: assert property (
        prot && !ls_tick && !prot_rise && !refresh
        |=> $stable(cnt))
        else $error("protected counter moved without a low-speed edge");
    a_refresh_reload: assert property (refresh && !prot_rise |=> cnt == WDT_RELOAD)
        else $error("refresh did not reload counter");
    a_stopped_hold: assert property (
        !running && !prot_rise && !refresh
        |=> $stable(cnt) && $stable(pre))
        else $error("stopped counter or prescaler moved");
    a_auto_start: assert property (done && !opt[WDT_AUTO_BIT] |-> running)
        else $error("auto start did not run");
    a_mode_freeze: assert property (
        !prot && (stop_mode || wait_mode) && !refresh
        |=> $stable(cnt) && $stable(pre))
        else $error("count moved in stop or wait mode");
    a_underflow_irq: assert property (
        underflow && !action
        |=> wdt_irq && !wdt_reset_req ##1 !wdt_irq)
        else $error("underflow interrupt not one pulse");
    a_underflow_reset: assert property (
        underflow && action
        |=> wdt_reset_req && !wdt_irq && cnt == WDT_RELOAD)
        else $error("underflow reset missing");
    a_prescale_ratio: assert property (
        running && !frozen && !prot && pre_tick
        |=> pre == WDT_PRE_ZERO
        ##1 (pre == WDT_PRE_ONE || $past(frozen || !running || prot)))
        else $error("prescaler did not wrap");
    a_prescale_limit: assert property (
        !psel && !prot && running && !frozen
        |=> pre <= WDT_PRE_LIM_16)
        else $error("prescaler passed divide-by-16 limit");
    a_wait_protected: assert property (
        prot && wait_mode && tick && cnt != WDT_CNT_ZERO && !refresh && !prot_rise
        |=> cnt == $past(cnt) - WDT_CNT_ONE)
        else $error("protected count stopped in wait");
    a_protect_load: assert property (
        prot_rise
        |=> cnt == WDT_PROT_LOAD && action && low_speed_osc_force_on)
        else $error("protection enable effects missing");
    a_option_fixed: assert property (done |=> $stable(opt))
        else $error("option byte changed after capture");
endmodule

//--- src/wdt_pkg.sv
/*
 watchdog timer unit: register map, field positions, reset values and counts.
 assumes nothing; imported by every design file of the block.
*/
package wdt_pkg;
    localparam int WDT_ADDR_W = 18;
    localparam int WDT_DATA_W = 32;
    localparam int WDT_CNT_W = 15;
    localparam int WDT_PRE_W = 7;
    localparam int WDT_OPT_W = 8;

    // register byte addresses
    localparam logic [17:0] WDT_ADDR_CTRL = 18'h00000;
    localparam logic [17:0] WDT_ADDR_REFRESH = 18'h00004;
    localparam logic [17:0] WDT_ADDR_START = 18'h00008;
    localparam logic [17:0] WDT_ADDR_PROTECT = 18'h0000C;
    localparam logic [17:0] WDT_ADDR_PMODE = 18'h00010;
    localparam logic [17:0] WDT_ADDR_STATUS = 18'h00014;
    // option byte: printed offset is an index, byte address is four times it
    localparam logic [15:0] WDT_OPT_INDEX = 16'hFFFF;
    localparam logic [17:0] WDT_ADDR_OPT = {WDT_OPT_INDEX, 2'b00};

    // field positions
    localparam int WDT_PSEL_BIT = 7;
    localparam int WDT_PROT_BIT = 7;
    localparam int WDT_ACTION_BIT = 2;
    localparam int WDT_AUTO_BIT = 0;
    localparam int WDT_PROT_INIT_BIT = 7;
    localparam int WDT_RUN_BIT = 15;

    // counter values
    localparam logic [14:0] WDT_RELOAD = 15'h7FFF;
    localparam logic [14:0] WDT_PROT_LOAD = 15'h0FFF;
    localparam logic [14:0] WDT_CNT_ZERO = 15'h0000;
    localparam logic [14:0] WDT_CNT_ONE = 15'h0001;
    localparam logic [6:0] WDT_PRE_ZERO = 7'h00;
    localparam logic [6:0] WDT_PRE_ONE = 7'h01;
    localparam logic [6:0] WDT_PRE_LIM_16 = 7'h0F;
    localparam logic [6:0] WDT_PRE_LIM_128 = 7'h7F;

    // refresh sequence bytes
    localparam logic [7:0] WDT_REFRESH_FIRST = 8'h00;
    localparam logic [7:0] WDT_REFRESH_SECOND = 8'hFF;

    // clocks after reset release before the synced option byte is trusted
    localparam logic [1:0] WDT_SETTLE = 2'h3;

    localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] WDT_RESP_DECERR = 2'h3;
endpackage

//--- src/wdt_reg_if.sv
/*
 register access carrier between the bus slave and the watchdog core.
 assumes one clock domain; strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
interface wdt_reg_if;
    import wdt_pkg::*;
    logic wr_stb;
    logic [WDT_ADDR_W-1:0] wr_addr;
    logic [WDT_DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic rd_stb;
    logic [WDT_ADDR_W-1:0] rd_addr;
    logic [WDT_DATA_W-1:0] rd_data;
    logic rd_hit;
    modport bus (output wr_stb, output wr_addr, output wr_data, output wr_strb,
        output rd_stb, output rd_addr, input wr_hit, input rd_data, input rd_hit);
    modport regs (input wr_stb, input wr_addr, input wr_data, input wr_strb,
        input rd_stb, input rd_addr, output wr_hit, output rd_data, output rd_hit);
endinterface

//--- src/wdt_sync2.sv
/*
 two flip-flop synchroniser for a group of pin levels.
 assumes inputs are asynchronous levels; only q is read downstream.
*/
`timescale 1ns/100ps
module wdt_sync2
    import wdt_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    if (W < 1)
    begin : g_check
        $error("wdt_sync2: W must be at least 1");
    end

    always_comb
    begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

//--- src/wdt_axil_slave.sv
/*
 axi4-lite slave: takes write address and data in either order, one write and
 one read under way at a time. assumes the register side answers combinationally.
*/
`timescale 1ns/100ps
module wdt_axil_slave
    import wdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WDT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [WDT_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [WDT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [WDT_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    wdt_reg_if.bus rif
);
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [WDT_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [WDT_DATA_W-1:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [WDT_DATA_W-1:0] next_rdata;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rif.wr_stb = aw_full && w_full && !s_axi_bvalid;
    assign rif.wr_addr = aw_addr;
    assign rif.wr_data = w_data;
    assign rif.wr_strb = w_strb;
    assign rif.rd_stb = s_axi_arvalid && s_axi_arready;
    assign rif.rd_addr = s_axi_araddr;

    always_comb
    begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (rif.wr_stb)
        begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = rif.wr_hit ? WDT_RESP_OKAY : WDT_RESP_DECERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (rif.rd_stb)
        begin
            next_rvalid = 1'b1;
            next_rdata = rif.rd_hit ? rif.rd_data : '0;
            next_rresp = rif.rd_hit ? WDT_RESP_OKAY : WDT_RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= WDT_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= WDT_RESP_OKAY;
            s_axi_rdata <= '0;
        end
        else
        begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule

//--- bench/wdt_top_tb.sv
/*
 bench for the watchdog timer unit: axi4-lite register access, start, rates,
 freeze, refresh, protection and underflow reset. assumes wdt_pkg and wdt_top.
*/
`timescale 1ns/100ps
module wdt_top_tb;
    import wdt_pkg::*;
    logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ls_clk, ls_run, stop_mode, wait_mode;
    logic irq, wreset, force_on;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] opt;
    int n_mismatch, tests_run, n_irq, n_rst;

    wdt_top wdt_top_inst (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_speed_osc_clk(ls_clk),
        .option_byte(opt), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .wdt_irq(irq), .wdt_reset_req(wreset), .low_speed_osc_force_on(force_on)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // low-speed clock runs only while enabled
    initial
    begin
        ls_clk = 1'b0;
        forever
        begin
            repeat (4) @(posedge ref_clk);
            ls_clk <= ls_run ? ~ls_clk : 1'b0;
        end
    end

    always @(posedge ref_clk)
    begin
        n_irq <= n_irq + (irq === 1'b1);
        n_rst <= n_rst + (wreset === 1'b1);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic ok(input string what, input logic cond);
        check(what, {31'h0, cond}, 32'h00000001);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic timed_out(input int n);
        if (n >= 40000)
        begin
            n_mismatch++;
            $display("CHECK FAILED wait bound expected done seen timeout");
            complete_run();
        end
    endtask

    task automatic axw(input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (awready === 1'b1 && awvalid === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1 && wvalid === 1'b1)
                wvalid <= 1'b0;
            timed_out(n);
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [17:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (arready === 1'b1 && arvalid === 1'b1)
                arvalid <= 1'b0;
            timed_out(n);
        end
        while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic t_idle();
        axr(WDT_ADDR_STATUS);
        check("status reset", rd, 32'h00007FFF);
        repeat (100) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        check("status held", rd, 32'h00007FFF);
        axw(WDT_ADDR_OPT, 32'h00000000);
        axr(WDT_ADDR_OPT);
        check("option byte", rd, 32'h00000081);
        axr(18'h00020);
        check("unmapped resp", {30'h0, rs}, {30'h0, WDT_RESP_DECERR});
        check("unmapped data", rd, 32'h00000000);
    endtask

    task automatic t_rate();
        logic [31:0] a;
        axw(WDT_ADDR_START, 32'h00000000);
        axr(WDT_ADDR_STATUS);
        ok("running", rd[WDT_RUN_BIT]);
        for (int i = 0; i < 2; i++)
        begin
            axw(WDT_ADDR_CTRL, i ? 32'h00000080 : 32'h00000000);
            axr(WDT_ADDR_STATUS);
            a = rd;
            repeat (i ? 12800 : 1600) @(posedge ref_clk);
            axr(WDT_ADDR_STATUS);
            ok("ticks", (a - rd) >= 100 && (a - rd) <= 101);
        end
    endtask

    task automatic t_freeze();
        logic [31:0] a;
        for (int i = 0; i < 2; i++)
        begin
            stop_mode <= (i == 0);
            wait_mode <= (i == 1);
            repeat (4) @(posedge ref_clk);
            axr(WDT_ADDR_STATUS);
            a = rd;
            repeat (600) @(posedge ref_clk);
            axr(WDT_ADDR_STATUS);
            check("frozen", rd, a);
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            repeat (600) @(posedge ref_clk);
            axr(WDT_ADDR_STATUS);
            ok("resumed", (a - rd) >= 4 && (a - rd) <= 5);
        end
    endtask

    task automatic t_refresh();
        logic [31:0] a;
        axr(WDT_ADDR_STATUS);
        a = rd;
        axw(WDT_ADDR_REFRESH, 32'h000000FF);
        axr(WDT_ADDR_STATUS);
        ok("lone second", rd[14:0] <= a[14:0]);
        axw(WDT_ADDR_REFRESH, 32'h00000000);
        axw(WDT_ADDR_REFRESH, 32'h000000FF);
        axr(WDT_ADDR_STATUS);
        ok("refreshed", rd[14:0] >= 15'h7FFE);
        repeat (300) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        a = rd;
        axw(WDT_ADDR_REFRESH, 32'h00000000);
        axw(WDT_ADDR_REFRESH, 32'h00000055);
        axw(WDT_ADDR_REFRESH, 32'h000000FF);
        axr(WDT_ADDR_STATUS);
        ok("broken pair", rd[14:0] <= a[14:0]);
    endtask

    task automatic t_protect();
        int k;
        int n;
        axw(WDT_ADDR_PMODE, 32'h00000004);
        axr(WDT_ADDR_PMODE);
        check("action bit", rd, 32'h00000004);
        axw(WDT_ADDR_PMODE, 32'h00000000);
        axw(WDT_ADDR_PROTECT, 32'h00000080);
        repeat (2) @(posedge ref_clk);
        ok("osc forced", force_on);
        axr(WDT_ADDR_PMODE);
        check("action forced", rd, 32'h00000004);
        axr(WDT_ADDR_STATUS);
        check("protect load", {17'h0, rd[14:0]}, 32'h00000FFF);
        repeat (300) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        check("no cpu count", {17'h0, rd[14:0]}, 32'h00000FFF);
        wait_mode <= 1'b1;
        ls_run <= 1'b1;
        repeat (800) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        k = 32'h00000FFF - rd[14:0];
        ok("slow count", k >= 98 && k <= 101);
        k = rd[14:0];
        n = 0;
        while (n_rst == 0 && n < 40000)
        begin
            @(posedge ref_clk);
            n++;
        end
        timed_out(n);
        ok("period", n >= k * 8 - 16 && n <= k * 8 + 32);
        check("no irq", n_irq, 0);
        axr(WDT_ADDR_STATUS);
        ok("underflow reload", rd[14:0] > 15'h0F00);
        wait_mode <= 1'b0;
        ls_run <= 1'b0;
    endtask

    task automatic t_auto();
        logic [31:0] a;
        opt <= 8'h80;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        a = rd;
        ok("auto running", a[WDT_RUN_BIT]);
        ok("reset reload", a[14:0] >= 15'h7FFE);
        repeat (160) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        ok("auto counts", rd[14:0] < a[14:0]);
        // protection on from the option byte, waiting for a start write
        opt <= 8'h01;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        axr(WDT_ADDR_STATUS);
        check("capture protect", rd, 32'h00000FFF);
        ok("capture osc", force_on);
        axr(WDT_ADDR_PMODE);
        check("capture action", rd, 32'h00000004);
    endtask

    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, ls_run, stop_mode, wait_mode} = 8'h00;
        awaddr = 18'h00000;
        araddr = 18'h00000;
        wdata = 32'h00000000;
        opt = 8'h81;
        {n_mismatch, tests_run, n_irq, n_rst} = 128'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        t_idle();
        t_rate();
        t_freeze();
        t_refresh();
        t_protect();
        t_auto();
        complete_run();
    end
endmodule
